/* design/dual_adc_serial_host_reader.sv */
// Host reader for a dual serial-output converter, with register port
`timescale 1ns/100ps
`default_nettype none
`include "adc_host_consts.svh"

module dual_adc_serial_host_reader
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire adc_host_pkg::addr_t addr,
    input wire adc_host_pkg::data_t wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output adc_host_pkg::data_t rd_data,
    output logic irq,
    output logic host_tx_frame_n,
    output logic host_rx_clock,
    output logic host_tx_data,
    input wire logic busy,
    input wire logic serial_out_first,
    input wire logic serial_out_second
);
    import adc_host_pkg::*;

    // Register decode used by both write and read paths
    function automatic logic hit(input addr_t a, input addr_t off);
        hit = (a == off);
    endfunction : hit

    state_t state_q;
    logic [3:0] ctrl_q;
    logic [`INT_W-1:0] int_stat_q;
    logic [`INT_W-1:0] int_mask_q;
    word_t tx_word_q;
    word_t tx_shift_q;
    word_t data_first_q;
    word_t data_second_q;
    word_t shift_first_q;
    word_t shift_second_q;
    logic [4:0] frame_len_q;
    logic [4:0] bit_cnt_q;
    logic frame_dual_q;
    logic [7:0] div_q;
    logic tick;
    logic [7:0] quiet_q;
    logic sclk_q;
    logic cs_n_q;
    logic txd_q;
    logic irq_q;
    data_t rd_data_q;
    logic [2:0] busy_s;
    logic [1:0] first_s;
    logic [1:0] second_s;
    logic conv_ev;
    logic fall_ev;
    logic rise_ev;
    logic start_ev;
    logic end_ev;
    logic go_q;
    logic [`INT_W-1:0] ev;

    assign rd_data = rd_data_q;
    assign irq = irq_q;
    assign host_tx_frame_n = cs_n_q;
    assign host_rx_clock = sclk_q;
    assign host_tx_data = txd_q;

    // Pin synchronisers; data lines read at the second stage, busy at the second and third
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_s <= 3'h0;
            first_s <= 2'h0;
            second_s <= 2'h0;
        end
        else
        begin
            busy_s <= {busy_s[1:0], busy};
            first_s <= {first_s[0], serial_out_first};
            second_s <= {second_s[0], serial_out_second};
        end
    end

    assign conv_ev = busy_s[2] && !busy_s[1];

    // Free-running half-period divider
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            div_q <= 8'h00;
        else if (tick)
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end

    assign tick = (div_q == 8'(`SCLK_HALF_CYC - 1));
    assign fall_ev = tick && (state_q == ST_FRAME) && sclk_q;
    assign rise_ev = tick && (state_q == ST_FRAME) && !sclk_q;
    // Frame opens only as the clock goes or stays high
    assign start_ev = tick && (state_q == ST_ARMED) && go_q && (!ctrl_q[`CTRL_CONT] || !sclk_q);
    assign end_ev = rise_ev && (bit_cnt_q == frame_len_q);

    // Serial clock; idles high unless free-running
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sclk_q <= 1'b1;
        else if (tick)
        begin
            if (ctrl_q[`CTRL_CONT])
                sclk_q <= !sclk_q;
            else if (state_q == ST_FRAME)
                sclk_q <= !sclk_q;
            else
                sclk_q <= 1'b1;
        end
    end

    // Sequencer
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            quiet_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (wr_stb && hit(addr, `REG_CTRL) && wr_data[`CTRL_ARM])
                        state_q <= ST_ARMED;
                ST_ARMED:
                    if (start_ev)
                        state_q <= ST_FRAME;
                ST_FRAME:
                    if (end_ev)
                    begin
                        state_q <= ST_QUIET;
                        quiet_q <= 8'h00;
                    end
                ST_QUIET:
                    if (quiet_q == 8'(`QUIET_CYC - 1))
                        state_q <= ST_IDLE;
                    else
                        quiet_q <= quiet_q + 8'h01;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Armed waits for the conversion-complete event
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            go_q <= 1'b0;
        else if (state_q != ST_ARMED)
            go_q <= 1'b0;
        else if (conv_ev)
            go_q <= 1'b1;
    end

    // Chip-select frame and dummy control word
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cs_n_q <= 1'b1;
            txd_q <= 1'b0;
            tx_shift_q <= 16'h0000;
        end
        else if (start_ev && go_q)
        begin
            cs_n_q <= 1'b0;
            txd_q <= tx_word_q[15];
            tx_shift_q <= {tx_word_q[14:0], 1'b0};
        end
        else if (end_ev)
        begin
            cs_n_q <= 1'b1;
            txd_q <= 1'b0;
        end
        else if (rise_ev)
        begin
            txd_q <= tx_shift_q[15];
            tx_shift_q <= {tx_shift_q[14:0], 1'b0};
        end
    end

    // Receive shifters, sampled on the falling edge
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_q <= 5'h00;
            frame_len_q <= `LEN_LONG;
            frame_dual_q <= 1'b0;
            shift_first_q <= 16'h0000;
            shift_second_q <= 16'h0000;
        end
        else if (start_ev && go_q)
        begin
            bit_cnt_q <= 5'h00;
            frame_len_q <= ctrl_q[`CTRL_LEN14] ? `LEN_SHORT : `LEN_LONG;
            frame_dual_q <= ctrl_q[`CTRL_DUAL];
            shift_first_q <= 16'h0000;
            shift_second_q <= 16'h0000;
        end
        else if (fall_ev && (bit_cnt_q != frame_len_q))
        begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            shift_first_q <= {shift_first_q[14:0], first_s[1]};
            if (frame_dual_q)
                shift_second_q <= {shift_second_q[14:0], second_s[1]};
        end
    end

    // Result registers, right justified
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            data_first_q <= 16'h0000;
            data_second_q <= 16'h0000;
        end
        else if (end_ev)
        begin
            data_first_q <= shift_first_q;
            data_second_q <= shift_second_q;
        end
    end

    // Software control registers
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= `CTRL_RESET;
            int_mask_q <= `MASK_RESET;
            tx_word_q <= `TX_WORD_RESET;
        end
        else if (wr_stb)
        begin
            if (hit(addr, `REG_CTRL))
                ctrl_q <= {wr_data[3:1], 1'b0};
            else if (hit(addr, `REG_INT_MASK))
                int_mask_q <= wr_data[`INT_W-1:0];
            else if (hit(addr, `REG_TX_WORD))
                tx_word_q <= wr_data[15:0];
        end
    end

    // Sticky events; a new event wins over a clear
    assign ev = {end_ev, conv_ev && (state_q == ST_ARMED)};
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            int_stat_q <= 2'h0;
        else if (wr_stb && hit(addr, `REG_INT_STAT))
            int_stat_q <= (int_stat_q & ~wr_data[`INT_W-1:0]) | ev;
        else
            int_stat_q <= int_stat_q | ev;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            irq_q <= 1'b0;
        else
            irq_q <= |(int_stat_q & int_mask_q);
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            rd_data_q <= 32'h0000_0000;
        else if (!rd_stb)
            rd_data_q <= 32'h0000_0000;
        else if (hit(addr, `REG_CTRL))
            rd_data_q <= {28'h0000000, ctrl_q};
        else if (hit(addr, `REG_STATUS))
            rd_data_q <= {28'h0000000, busy_s[1], !cs_n_q, state_q};
        else if (hit(addr, `REG_INT_STAT))
            rd_data_q <= {30'h00000000, int_stat_q};
        else if (hit(addr, `REG_INT_MASK))
            rd_data_q <= {30'h00000000, int_mask_q};
        else if (hit(addr, `REG_DATA_FIRST))
            rd_data_q <= {16'h0000, data_first_q};
        else if (hit(addr, `REG_DATA_SECOND))
            rd_data_q <= {16'h0000, data_second_q};
        else if (hit(addr, `REG_TX_WORD))
            rd_data_q <= {16'h0000, tx_word_q};
        else
            rd_data_q <= 32'h0000_0000;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    property p_frame_low;
        (state_q == ST_FRAME) == !cs_n_q;
    endproperty
    a_frame_low: assert property (p_frame_low)
        else $error("chip-select level disagrees with frame state");

    property p_frame_len;
        $rose(cs_n_q) |-> ($past(bit_cnt_q) == $past(frame_len_q))
            && ($past(frame_len_q) == 5'h10 || $past(frame_len_q) == 5'h0E);
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame closed with wrong bit count");

    property p_sample_fall;
        fall_ev |=> !sclk_q && (bit_cnt_q == $past(bit_cnt_q) + 5'h01);
    endproperty
    a_sample_fall: assert property (p_sample_fall)
        else $error("sample not taken on a falling clock edge");

    property p_after_busy;
        $fell(cs_n_q) |-> $past(go_q) && ($past(state_q) == ST_ARMED);
    endproperty
    a_after_busy: assert property (p_after_busy)
        else $error("read frame opened before conversion complete");

    property p_dummy_word;
        $fell(cs_n_q) |-> (txd_q == $past(tx_word_q[15]));
    endproperty
    a_dummy_word: assert property (p_dummy_word)
        else $error("control word not started with frame");

    property p_tx_idle;
        (cs_n_q && !$rose(cs_n_q)) |-> !txd_q;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("transmit data active outside frame");

    property p_dual_shift;
        (fall_ev && frame_dual_q && (bit_cnt_q != frame_len_q))
            |=> (shift_second_q[0] == $past(second_s[1]))
            && (shift_first_q[0] == $past(first_s[1]));
    endproperty
    a_dual_shift: assert property (p_dual_shift)
        else $error("data lines not captured together");

    property p_idle_high;
        (state_q == ST_IDLE && !ctrl_q[`CTRL_CONT]) |-> ##[0:8] sclk_q;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("gated clock not parked high outside frame");

    property p_free_clock;
        (tick && ctrl_q[`CTRL_CONT]) |=> (sclk_q != $past(sclk_q));
    endproperty
    a_free_clock: assert property (p_free_clock)
        else $error("free clock missed a toggle");

    property p_quiet;
        $rose(cs_n_q) |-> (state_q == ST_QUIET) ##1 (cs_n_q && state_q == ST_QUIET)[*8];
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("new activity within quiet time");

    c_single: cover property ($rose(cs_n_q) && !frame_dual_q);
    c_dual: cover property ($rose(cs_n_q) && frame_dual_q && frame_len_q == 5'h0E);
    c_free: cover property ($fell(cs_n_q) && ctrl_q[`CTRL_CONT]);
    c_irq: cover property ($rose(irq_q));

endmodule : dual_adc_serial_host_reader
`default_nettype wire

/* design/adc_host_consts.svh */
// Offsets, fields, reset values and timing counts of the serial reader host
`ifndef ADC_HOST_CONSTS_SVH
`define ADC_HOST_CONSTS_SVH

`define ADDR_W 8
`define DATA_W 32
`define WORD_W 16

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_STAT 8'h08
`define REG_INT_MASK 8'h0C
`define REG_DATA_FIRST 8'h10
`define REG_DATA_SECOND 8'h14
`define REG_TX_WORD 8'h18

`define CTRL_ARM 0
`define CTRL_LEN14 1
`define CTRL_DUAL 2
`define CTRL_CONT 3

`define INT_CONV_DONE 0
`define INT_READ_DONE 1
`define INT_W 2

`define CTRL_RESET 4'h4
`define MASK_RESET 2'h0
`define TX_WORD_RESET 16'h0000

`define LEN_LONG 5'h10
`define LEN_SHORT 5'h0E

`define CLK_NS 5
`define SCLK_HALF_NS 40
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`define QUIET_NS 100
`define QUIET_CYC ((`QUIET_NS + `CLK_NS - 1) / `CLK_NS)

`endif

/* design/adc_host_pkg.sv */
// Types shared by the serial reader host
package adc_host_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_FRAME = 2'b11,
        ST_QUIET = 2'b10
    } state_t;

    typedef logic [7:0] addr_t;
    typedef logic [31:0] data_t;
    typedef logic [15:0] word_t;

endpackage : adc_host_pkg

/* test/dual_adc_model.sv */
// Behavioural dual converter: busy flag and two MSB-first shifters
`timescale 1ns/100ps
`default_nettype none

module dual_adc_model
(
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic convert,
    input wire logic [15:0] word_a,
    input wire logic [15:0] word_b,
    output logic busy,
    output logic serial_out_first,
    output logic serial_out_second
);
    logic [15:0] sh_a;
    logic [15:0] sh_b;

    initial
    begin
        busy = 1'b0;
        sh_a = 16'h0000;
        sh_b = 16'h0000;
    end

    // Busy high for the whole conversion, its fall is the done event
    always @(posedge convert)
    begin
        busy = 1'b1;
        #600 busy = 1'b0;
    end

    // Selection presents the MSB, each falling clock the next bit
    always @(negedge cs_n)
    begin
        sh_a = word_a;
        sh_b = word_b;
    end

    always @(negedge sclk)
        if (!cs_n)
        begin
            sh_a = {sh_a[14:0], 1'b0};
            sh_b = {sh_b[14:0], 1'b0};
        end

    // Released lines show the inverse of the last bit, never a stale copy
    assign serial_out_first = cs_n ? ~sh_a[15] : sh_a[15];
    assign serial_out_second = cs_n ? ~sh_b[15] : sh_b[15];
endmodule : dual_adc_model
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the dual converter serial host reader
`timescale 1ns/100ps
`default_nettype none
`include "adc_host_consts.svh"

module tb;
    import adc_host_pkg::*;
    logic ref_clk;
    logic nrst;
    addr_t addr;
    data_t wr_data;
    logic wr_stb;
    logic rd_stb;
    data_t rd_data;
    logic irq;
    logic frame_n;
    logic sclk;
    logic txd;
    logic busy;
    logic sdo_a;
    logic sdo_b;
    logic convert;
    word_t word_a;
    word_t word_b;
    word_t tx_cap;
    int error_cnt;
    int total_checks;
    int cyc;
    int falls;
    int low_cyc;

    dual_adc_serial_host_reader dut
    (
        .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .irq(irq),
        .host_tx_frame_n(frame_n), .host_rx_clock(sclk), .host_tx_data(txd),
        .busy(busy), .serial_out_first(sdo_a), .serial_out_second(sdo_b)
    );

    dual_adc_model adc
    (
        .cs_n(frame_n), .sclk(sclk), .convert(convert), .word_a(word_a),
        .word_b(word_b), .busy(busy), .serial_out_first(sdo_a),
        .serial_out_second(sdo_b)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Frame length, falling clock count and transmitted bits
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (!frame_n)
            low_cyc <= low_cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    always @(negedge sclk)
        if (!frame_n)
        begin
            falls++;
            tx_cap = {tx_cap[14:0], txd};
        end

    task automatic chk(input string what, input data_t exp, input data_t got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input addr_t a, input data_t d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input addr_t a, input data_t exp, input string what);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1 chk(what, exp, rd_data);
    endtask : rd

    task automatic pulse_convert();
        @(posedge ref_clk);
        convert <= 1'b1;
        @(posedge ref_clk);
        convert <= 1'b0;
    endtask : pulse_convert

    task automatic wait_frame(input logic lvl);
        int n;
        n = 0;
        while (frame_n !== lvl && n < 2000)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("frame level", data_t'(lvl), data_t'(frame_n));
    endtask : wait_frame

    // One armed conversion and framed read, judged at the pins and registers
    task automatic run_frame(input data_t ctrl, input int nb, input data_t exp_a,
        input data_t exp_b, input logic exp_irq);
        wr(`REG_TX_WORD, 32'h0000A5C3);
        wr(`REG_CTRL, ctrl);
        falls = 0;
        low_cyc = 0;
        tx_cap = 16'h0000;
        pulse_convert();
        wait_frame(1'b0);
        chk("busy at frame", 32'h0, data_t'(busy));
        wr(`REG_CTRL, ctrl);
        rd(`REG_STATUS, 32'h7, "status in frame");
        wait_frame(1'b1);
        repeat (2) @(posedge ref_clk);
        chk("frame cycles", data_t'(nb * 16), data_t'(low_cyc));
        chk("clock falls", data_t'(nb), data_t'(falls));
        chk("tx word", data_t'(16'hA5C3 >> (16 - nb)), data_t'(tx_cap));
        chk("irq", data_t'(exp_irq), data_t'(irq));
        rd(`REG_DATA_FIRST, exp_a, "first data");
        rd(`REG_DATA_SECOND, exp_b, "second data");
        rd(`REG_INT_STAT, 32'h3, "events");
        wr(`REG_INT_STAT, 32'h3);
        rd(`REG_INT_STAT, 32'h0, "events cleared");
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", 32'h0, data_t'(irq));
        repeat (25) @(posedge ref_clk);
        rd(`REG_STATUS, 32'h0, "idle after quiet");
    endtask : run_frame

    task automatic t_reset();
        chk("frame idle", 32'h1, data_t'(frame_n));
        chk("clock idle", 32'h1, data_t'(sclk));
        chk("tx idle", 32'h0, data_t'(txd));
        rd(`REG_CTRL, data_t'(`CTRL_RESET), "ctrl reset");
        rd(`REG_INT_MASK, 32'h0, "mask reset");
        rd(`REG_TX_WORD, 32'h0, "tx word reset");
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0, "unmapped");
        pulse_convert();
        repeat (200) @(posedge ref_clk);
        rd(`REG_INT_STAT, 32'h0, "unarmed events");
        chk("unarmed frame", 32'h1, data_t'(frame_n));
        $display("Test reset done");
    endtask : t_reset

    task automatic t_dual16();
        wr(`REG_INT_MASK, 32'h1);
        run_frame(32'h5, 16, data_t'(word_a), data_t'(word_b), 1'b1);
        $display("Test dual 16-bit done");
    endtask : t_dual16

    task automatic t_single14();
        wr(`REG_INT_MASK, 32'h0);
        run_frame(32'h3, 14, data_t'(word_a[15:2]), 32'h0, 1'b0);
        chk("clock idle high", 32'h1, data_t'(sclk));
        $display("Test single 14-bit done");
    endtask : t_single14

    task automatic t_cont();
        logic s;
        wr(`REG_CTRL, 32'h8);
        @(posedge ref_clk);
        s = sclk;
        repeat (8) @(posedge ref_clk);
        chk("free clock toggles", data_t'(!s), data_t'(sclk));
        chk("frame idle free", 32'h1, data_t'(frame_n));
        run_frame(32'hD, 16, data_t'(word_a), data_t'(word_b), 1'b0);
        wr(`REG_CTRL, 32'h4);
        $display("Test free clock done");
    endtask : t_cont

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        nrst = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        convert = 1'b0;
        word_a = 16'h9A5C;
        word_b = 16'h36E1;
        error_cnt = 0;
        total_checks = 0;
        cyc = 0;
        falls = 0;
        low_cyc = 0;
        tx_cap = 16'h0000;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        #1 t_reset();
        t_dual16();
        t_single14();
        t_cont();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
